/* File: inc/oscm_map.svh */
// register map, field positions and timing counts of the osd second colour and mesh block
// assumes an apb slave with 32-bit data and word index addressing
`ifndef OSCM_MAP_SVH
`define OSCM_MAP_SVH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define OSCM_IDX_MST    8'h04
`define OSCM_IDX_MEND   8'h05
`define OSCM_IDX_CTL    8'h07
`define OSCM_IDX_POS    8'h08
`define OSCM_IDX_MCTL   8'h09
`define OSCM_IDX_STAT   8'h0a
`define OSCM_IDX_MASK   8'h0b

// ----------------------------------------
// fields
// ----------------------------------------
`define OSCM_CTL_EN     7
`define OSCM_CTL_CLR    6:4
`define OSCM_CTL_ROW    3:0
`define OSCM_POS_OPT    6
`define OSCM_POS_VAL    5:0
`define OSCM_MCTL_EN    0
`define OSCM_MCTL_SWM   1
`define OSCM_MCTL_SWP   2
`define OSCM_MCTL_EOI   3
`define OSCM_ROW_LAST   4'h9
`define OSCM_RSV3       3'h7
`define OSCM_RSV1       1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define OSCM_POS_OFFSET 6'h03
`define OSCM_HALF_DOTS  4'h6
`define OSCM_HALF_MAX   6'h3f

`endif

/* File: inc/oscm_pkg.sv */
// types shared by the osd second colour and mesh block
// assumes the map header is included alongside
package oscm_pkg;

   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_H    = 2'b01,
      SVC_V    = 2'b10
   } oscm_svc_t;

   typedef struct packed {
      logic hsync;
      logic vsync;
      logic dot;
   } oscm_vid_t;

   typedef struct packed {
      logic [2:0] fg_rgb;
      logic       fg_on;
      logic       bg_on;
      logic [3:0] row;
      logic       line_act;
   } oscm_pix_t;

   typedef struct packed {
      oscm_vid_t s1;
      oscm_vid_t s2;
   } oscm_sync_st_t;

   typedef struct packed {
      logic [1:0] status;
      logic       irq;
   } oscm_irq_st_t;

endpackage

/* File: rtl/oscm_sync.sv */
// two-stage synchroniser for the video pins
// assumes pins are asynchronous to pclk
`timescale 1ns/1ps
module oscm_sync
   import oscm_pkg::*;
(
   // clock and reset
   input  wire logic      pclk,
   input  wire logic      presetn,
   // pins and synchronised copy
   input  wire oscm_vid_t pin_in,
   output oscm_vid_t      pin_sync
);

   oscm_sync_st_t st_r;
   oscm_sync_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_sync = st_r.s2;

endmodule

/* File: rtl/oscm_irq.sv */
// sticky sync interrupt status, mask gating and pending hold
// assumes one-cycle event pulses and a one-cycle read-clear pulse
`timescale 1ns/1ps
module oscm_irq
   import oscm_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // events and control
   input  wire logic [1:0] ev,
   input  wire logic       rd_clr,
   input  wire logic [1:0] mask,
   input  wire logic [1:0] busy,
   input  wire logic       hold_en,
   // state
   output logic [1:0]      status,
   output logic            irq
);

   oscm_irq_st_t st_r;
   oscm_irq_st_t st_nxt;
   logic [1:0]   accept;

   always_comb begin
      st_nxt = st_r;
      // other source in service drops the event unless held
      accept = ev & ~({busy[0], busy[1]} & {2{~hold_en}});
      st_nxt.status = (st_r.status & ~{2{rd_clr}}) | accept;
      st_nxt.irq    = |(st_nxt.status & mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign status = st_r.status;
   assign irq    = st_r.irq;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_drop_other: assert property (ev[1] && busy[0] && !hold_en && !st_r.status[1]
                                  |=> !st_r.status[1])
      else $error("vsync event not dropped during hsync service");
   a_hold_other: assert property (ev[0] && busy[1] && hold_en |=> st_r.status[0])
      else $error("hsync event not held during vsync service");

endmodule

/* File: rtl/oscm_top.sv */
// osd second colour bar and mesh window overlay with apb registers
// assumes sync and dot pins are asynchronous, pixel attributes come on pclk
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "oscm_map.svh"
module oscm_top
   import oscm_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // video pins
   input  wire oscm_vid_t   vid_pin,
   // pixel attributes
   input  wire oscm_pix_t   pix,
   // overlay out
   output logic [2:0]       rgb_out,
   output logic             overlay_blank,
   // interrupt
   output logic             irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  ctl;
      logic [6:0]  pos;
      logic [4:0]  mst;
      logic [4:0]  mend;
      logic [2:0]  mctl;
      logic [1:0]  mask;
      oscm_svc_t   svc;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      oscm_vid_t   vid_d;
      logic [5:0]  half;
      logic [3:0]  dotc;
      logic        dotpar;
      logic        linepar;
      logic        field;
      logic [2:0]  rgb;
      logic        blank;
   } oscm_top_st_t;

   oscm_top_st_t st_r;
   oscm_top_st_t st_nxt;

   oscm_vid_t    vid_s;
   logic [1:0]   status;
   logic         irq_w;
   logic [1:0]   ev;
   logic         rd_clr;
   logic [1:0]   busy;
   logic [7:0]   idx;
   logic         addr_ok;
   logic         setup;
   logic         wr_acc;
   logic         rd_acc;
   logic         hs_rise;
   logic         vs_rise;
   logic         dot_rise;
   logic         row_hit;
   logic         sc_hit;
   logic [5:0]   col_half;
   logic [4:0]   col;
   logic         in_mesh;
   logic         mesh_phase;
   logic         mesh_clear;
   logic [31:0]  rd_mux;

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   oscm_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin_in   (vid_pin),
      .pin_sync (vid_s)
   );

   oscm_irq u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (ev),
      .rd_clr  (rd_clr),
      .mask    (st_nxt.mask),
      .busy    (busy),
      .hold_en (st_r.pos[`OSCM_POS_OPT]),
      .status  (status),
      .irq     (irq_w)
   );

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign idx     = paddr[9:2];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                    (idx == `OSCM_IDX_MST  || idx == `OSCM_IDX_MEND ||
                     idx == `OSCM_IDX_CTL  || idx == `OSCM_IDX_POS  ||
                     idx == `OSCM_IDX_MCTL || idx == `OSCM_IDX_STAT ||
                     idx == `OSCM_IDX_MASK);
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && st_r.ready && pwrite && addr_ok;
   assign rd_acc  = psel && penable && st_r.ready && !pwrite && addr_ok;
   assign rd_clr  = rd_acc && (idx == `OSCM_IDX_STAT);

   always_comb begin
      rd_mux = 32'h0;
      case (idx)
         `OSCM_IDX_MST: begin
            rd_mux[7:0] = {`OSCM_RSV3, st_r.mst};
         end
         `OSCM_IDX_MEND: begin
            rd_mux[7:0] = {`OSCM_RSV3, st_r.mend};
         end
         `OSCM_IDX_CTL: begin
            rd_mux[7:0] = st_r.ctl;
         end
         `OSCM_IDX_POS: begin
            rd_mux[7:0] = {`OSCM_RSV1, st_r.pos};
         end
         `OSCM_IDX_MCTL: begin
            rd_mux[2:0] = st_r.mctl;
         end
         `OSCM_IDX_STAT: begin
            rd_mux[1:0] = status;
         end
         `OSCM_IDX_MASK: begin
            rd_mux[1:0] = st_r.mask;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
      if (!addr_ok) begin
         rd_mux = 32'h0;
      end
   end

   // ----------------------------------------
   // video timing
   // ----------------------------------------
   assign hs_rise  = vid_s.hsync && !st_r.vid_d.hsync;
   assign vs_rise  = vid_s.vsync && !st_r.vid_d.vsync;
   assign dot_rise = vid_s.dot && !st_r.vid_d.dot;
   assign ev       = {vs_rise, hs_rise};
   assign busy     = {st_r.svc == SVC_V, st_r.svc == SVC_H};

   // half-column counted from the screen offset
   assign col_half = st_r.half - `OSCM_POS_OFFSET;
   assign col      = col_half[5:1];

   // ----------------------------------------
   // second colour
   // ----------------------------------------
   assign row_hit = (pix.row == st_r.ctl[`OSCM_CTL_ROW]) &&
                    (pix.row <= `OSCM_ROW_LAST);
   assign sc_hit  = st_r.ctl[`OSCM_CTL_EN] && row_hit &&
                    (st_r.half >= st_r.pos[`OSCM_POS_VAL]);

   // ----------------------------------------
   // mesh, phase from the field toggle unless the software phase is selected
   // ----------------------------------------
   assign in_mesh    = st_r.mctl[`OSCM_MCTL_EN] && pix.line_act &&
                       (st_r.half >= `OSCM_POS_OFFSET) &&
                       (col >= st_r.mst) &&
                       (col < st_r.mend);
   assign mesh_phase = st_r.mctl[`OSCM_MCTL_SWM] ? st_r.mctl[`OSCM_MCTL_SWP] :
                       st_r.field;
   assign mesh_clear = in_mesh && !pix.fg_on &&
                       !(st_r.dotpar ^ st_r.linepar ^ mesh_phase);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.vid_d = vid_s;

      // apb answer, no wait states
      st_nxt.ready = setup;
      if (setup) begin
         st_nxt.err   = !addr_ok;
         st_nxt.rdata = pwrite ? 32'h0 : rd_mux;
      end
      if (psel && penable && st_r.ready) begin
         st_nxt.ready = 1'b0;
         st_nxt.err   = 1'b0;
         st_nxt.rdata = 32'h0;
      end

      if (wr_acc) begin
         case (idx)
            `OSCM_IDX_MST: begin
               st_nxt.mst = pwdata[4:0];
            end
            `OSCM_IDX_MEND: begin
               st_nxt.mend = pwdata[4:0];
            end
            `OSCM_IDX_CTL: begin
               st_nxt.ctl = pwdata[7:0];
            end
            `OSCM_IDX_POS: begin
               st_nxt.pos = pwdata[6:0];
            end
            `OSCM_IDX_MCTL: begin
               st_nxt.mctl = pwdata[2:0];
            end
            `OSCM_IDX_MASK: begin
               st_nxt.mask = pwdata[1:0];
            end
            default: begin
               st_nxt.mctl = st_r.mctl;
            end
         endcase
      end

      // service tracking for sync interrupts
      case (st_r.svc)
         SVC_IDLE: begin
            if (rd_clr && status[0]) begin
               st_nxt.svc = SVC_H;
            end else if (rd_clr && status[1]) begin
               st_nxt.svc = SVC_V;
            end
         end
         SVC_H, SVC_V: begin
            if (wr_acc && idx == `OSCM_IDX_MCTL && pwdata[`OSCM_MCTL_EOI]) begin
               st_nxt.svc = SVC_IDLE;
            end
         end
         default: begin
            st_nxt.svc = SVC_IDLE;
         end
      endcase

      // line and field parity
      if (hs_rise) begin
         st_nxt.linepar = !st_r.linepar;
      end
      if (vs_rise) begin
         st_nxt.linepar = 1'b0;
         st_nxt.field   = !st_r.field;
      end

      // half-column stepping
      if (!pix.line_act || hs_rise) begin
         st_nxt.half   = `OSCM_POS_OFFSET;
         st_nxt.dotc   = 4'h0;
         st_nxt.dotpar = 1'b0;
      end else if (dot_rise) begin
         st_nxt.dotpar = !st_r.dotpar;
         if (st_r.dotc == `OSCM_HALF_DOTS - 4'h1) begin
            st_nxt.dotc = 4'h0;
            if (st_r.half != `OSCM_HALF_MAX) begin
               st_nxt.half = st_r.half + 6'h1;
            end
         end else begin
            st_nxt.dotc = st_r.dotc + 4'h1;
         end
      end

      // pixel out
      st_nxt.rgb   = sc_hit ? st_r.ctl[`OSCM_CTL_CLR] : pix.fg_rgb;
      st_nxt.blank = (pix.fg_on || pix.bg_on) && !mesh_clear;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r      <= '0;
         st_r.half <= `OSCM_POS_OFFSET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata        = st_r.rdata;
   assign pready        = st_r.ready;
   assign pslverr       = st_r.err;
   assign rgb_out       = st_r.rgb;
   assign overlay_blank = st_r.blank;
   assign irq           = irq_w;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   a_apb_ready: assert property (s_setup |=> s_access or !psel)
      else $error("apb access did not complete in one cycle");
   a_sc_disabled: assert property (!st_r.ctl[`OSCM_CTL_EN] |=> rgb_out == $past(pix.fg_rgb))
      else $error("second colour shown while disabled");
   a_sc_colour: assert property (sc_hit |=> rgb_out == $past(st_r.ctl[`OSCM_CTL_CLR]))
      else $error("second colour value wrong");
   a_row_other: assert property (pix.row != st_r.ctl[`OSCM_CTL_ROW] |=>
                                 rgb_out == $past(pix.fg_rgb))
      else $error("second colour on unselected row");
   a_before_pos: assert property (st_r.half < st_r.pos[`OSCM_POS_VAL] |=>
                                  rgb_out == $past(pix.fg_rgb))
      else $error("second colour before its position");
   a_half_step: assert property (pix.line_act && !hs_rise && dot_rise &&
                                 st_r.dotc == `OSCM_HALF_DOTS - 4'h1 &&
                                 st_r.half != `OSCM_HALF_MAX |=>
                                 st_r.half == $past(st_r.half) + 6'h1)
      else $error("half-column did not advance");
   a_mesh_clear: assert property (mesh_clear |=> !overlay_blank)
      else $error("mesh pixel not transparent");
   a_mesh_outside: assert property (pix.bg_on && col < st_r.mst |=> overlay_blank)
      else $error("mesh before start column");
   a_mesh_end: assert property (pix.bg_on && col >= st_r.mend |=> overlay_blank)
      else $error("mesh after end column");
   a_irq_level: assert property (irq == |(status & st_r.mask))
      else $error("interrupt level mismatch");

endmodule

/* File: testbench/oscm_video_src.sv */
// video sync source and overlay mixer model for the osd block
// assumes the bench calls its tasks and pclk is the system clock
`timescale 1ns/1ps
module oscm_video_src
   import oscm_pkg::*;
(
   // overlay blank and clock
   input  wire logic overlay_blank,
   input  wire logic pclk,
   // pins to the block
   output oscm_vid_t vid
);
   int   dot_cnt;
   int   transp_cnt;
   logic in_line;

   initial begin
      vid        = '0;
      dot_cnt    = 0;
      transp_cnt = 0;
      in_line    = 1'b0;
   end

   // --------------------------------
   // mixer: picture shows where overlay_blank is low
   // --------------------------------
   always @(posedge pclk) begin
      if (in_line && overlay_blank === 1'b0) begin
         transp_cnt <= transp_cnt + 1;
      end
   end

   // --------------------------------
   // sync pulses, idle low between them
   // --------------------------------
   task automatic sync_pulse(input logic vert);
      @(posedge pclk);
      if (vert) begin
         vid.vsync <= 1'b1;
      end else begin
         vid.hsync <= 1'b1;
      end
      repeat (4) @(posedge pclk);
      vid.hsync <= 1'b0;
      vid.vsync <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask

   // dot clock runs only inside a line
   task automatic line(input int n);
      sync_pulse(1'b0);
      dot_cnt <= 0;
      in_line <= 1'b1;
      repeat (n) begin
         @(posedge pclk);
         vid.dot <= 1'b1;
         dot_cnt <= dot_cnt + 1;
         repeat (2) @(posedge pclk);
         vid.dot <= 1'b0;
         @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      in_line <= 1'b0;
   endtask
endmodule

/* File: testbench/osd_second_color_mesh_tb_top.sv */
// self-checking bench for the osd second colour and mesh block
// assumes the video source model drives the sync and dot pins
`timescale 1ns/1ps
`include "oscm_map.svh"
`define OSCM_CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module osd_second_color_mesh_tb_top;
   import oscm_pkg::*;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   oscm_vid_t   vid_pin;
   oscm_pix_t   pix     = '0;
   logic [2:0]  rgb_out;
   logic        overlay_blank;
   logic        irq;
   int          err_count = 0;
   int          checks    = 0;

   always #2.5 pclk = ~pclk;

   oscm_top oscm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .vid_pin(vid_pin), .pix(pix), .rgb_out(rgb_out),
      .overlay_blank(overlay_blank), .irq(irq));

   oscm_video_src oscm_video_src_inst (.overlay_blank(overlay_blank), .pclk(pclk),
      .vid(vid_pin));

   // --------------------------------
   // apb master
   // --------------------------------
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, idx, d, rd, er);
      `OSCM_CHK(er, 1'b0)
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, idx, 32'h0, rd, er);
      `OSCM_CHK(rd, e)
   endtask

   // --------------------------------
   // scenarios
   // --------------------------------
   task automatic reg_test();
      logic [31:0] rd;
      logic        er;
      rchk(`OSCM_IDX_CTL, 32'h0);
      rchk(`OSCM_IDX_POS, 32'h80);
      rchk(`OSCM_IDX_MST, 32'he0);
      wr(`OSCM_IDX_CTL, 32'ha5);
      rchk(`OSCM_IDX_CTL, 32'ha5);
      wr(`OSCM_IDX_MST, 32'h1f);
      rchk(`OSCM_IDX_MST, 32'hff);
      apb(1'b1, 8'h0c, 32'hff, rd, er);
      `OSCM_CHK(er, 1'b1)
      apb(1'b0, 8'h0c, 32'h0, rd, er);
      `OSCM_CHK({er, rd}, {1'b1, 32'h0})
   endtask

   // position written before the enable; half h sampled mid-way
   task automatic sc_line(input logic [7:0] c, input logic [7:0] p, input logic [3:0] r,
                          input logic [2:0] fg);
      logic [2:0] e;
      wr(`OSCM_IDX_POS, {24'h0, p});
      wr(`OSCM_IDX_CTL, {24'h0, c});
      pix <= '{fg_rgb: fg, fg_on: 1'b1, bg_on: 1'b0, row: r, line_act: 1'b1};
      fork
         oscm_video_src_inst.line(48);
         for (int h = 0; h < 8; h++) begin
            wait (oscm_video_src_inst.dot_cnt == 6 * h + 3);
            repeat (6) @(posedge pclk);
            e = (c[7] && r == c[3:0] && r <= 4'h9 && 3 + h >= p[5:0]) ? c[6:4] : fg;
            `OSCM_CHK(rgb_out, e)
         end
      join
   endtask

   task automatic mesh_line(input logic [7:0] ms, input logic [7:0] me, input logic [7:0] mc,
                            input logic act, input logic exp);
      int t0;
      wr(`OSCM_IDX_MST, {24'h0, ms});
      wr(`OSCM_IDX_MEND, {24'h0, me});
      wr(`OSCM_IDX_MCTL, {24'h0, mc});
      pix <= '{fg_rgb: 3'h7, fg_on: 1'b0, bg_on: 1'b1, row: 4'h0, line_act: act};
      t0 = oscm_video_src_inst.transp_cnt;
      oscm_video_src_inst.line(24);
      `OSCM_CHK(oscm_video_src_inst.transp_cnt > t0, exp)
   endtask

   task automatic irq_test();
      logic [31:0] rd;
      logic        er;
      wr(`OSCM_IDX_MCTL, 32'h8);
      apb(1'b0, `OSCM_IDX_STAT, 32'h0, rd, er);
      wr(`OSCM_IDX_MCTL, 32'h8);
      wr(`OSCM_IDX_MASK, 32'h0);
      wr(`OSCM_IDX_POS, 32'h0);
      oscm_video_src_inst.sync_pulse(1'b0);
      `OSCM_CHK(irq, 1'b0)
      wr(`OSCM_IDX_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      `OSCM_CHK(irq, 1'b1)
      rchk(`OSCM_IDX_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      `OSCM_CHK(irq, 1'b0)
      oscm_video_src_inst.sync_pulse(1'b1);
      rchk(`OSCM_IDX_STAT, 32'h0);
      wr(`OSCM_IDX_MCTL, 32'h8);
      wr(`OSCM_IDX_POS, 32'h40);
      oscm_video_src_inst.sync_pulse(1'b0);
      rchk(`OSCM_IDX_STAT, 32'h1);
      oscm_video_src_inst.sync_pulse(1'b1);
      wr(`OSCM_IDX_MASK, 32'h3);
      repeat (3) @(posedge pclk);
      `OSCM_CHK(irq, 1'b1)
      rchk(`OSCM_IDX_STAT, 32'h2);
      wr(`OSCM_IDX_MCTL, 32'h8);
      // vsync service with hold on keeps the hsync event
      oscm_video_src_inst.sync_pulse(1'b1);
      rchk(`OSCM_IDX_STAT, 32'h2);
      oscm_video_src_inst.sync_pulse(1'b0);
      rchk(`OSCM_IDX_STAT, 32'h1);
      wr(`OSCM_IDX_MCTL, 32'h8);
   endtask

   task automatic test_done();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // --------------------------------
   // main sequence and watchdog
   // --------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      reg_test();
      sc_line(8'he7, 8'h06, 4'h7, 3'h1);
      sc_line(8'hd2, 8'h06, 4'h3, 3'h2);
      sc_line(8'h67, 8'h06, 4'h7, 3'h4);
      sc_line(8'ha9, 8'h03, 4'h9, 3'h5);
      sc_line(8'hba, 8'h03, 4'ha, 3'h0);
      sc_line(8'h90, 8'h0a, 4'h0, 3'h7);
      mesh_line(8'h00, 8'h02, 8'h01, 1'b1, 1'b1);
      mesh_line(8'h01, 8'h02, 8'h01, 1'b1, 1'b1);
      mesh_line(8'h02, 8'h02, 8'h01, 1'b1, 1'b0);
      mesh_line(8'h00, 8'h02, 8'h00, 1'b1, 1'b0);
      mesh_line(8'h00, 8'h02, 8'h03, 1'b1, 1'b1);
      mesh_line(8'h00, 8'h02, 8'h07, 1'b1, 1'b1);
      mesh_line(8'h00, 8'h02, 8'h01, 1'b0, 1'b0);
      wr(`OSCM_IDX_MCTL, 32'h0);
      irq_test();
      test_done();
   end

   initial begin
      #100000;
      err_count++;
      test_done();
   end
endmodule
